// ### mbmae_defines.vh
// constants for the branch, misc and add execution unit: opcodes, states, timing, addresses
// assumes an outside decoder that turns instruction words into the opcode classes below
// Behaviour
// - zero-test skips take one cycle, keep flags, skip on zero; acc form always loads
// - bit-test skips pick bit 0..7; one skips on zero, other on one; flags kept
// - a taken skip adds one instruction cycle of four clocks
// - writing the program counter low byte adds one instruction cycle
// - inc/dec-and-skip write memory back, skip on zero result, with both penalties
// - inc/dec-and-skip to accumulator, skip on zero, flags kept, skip penalty only
// - call and every return form take two cycles and keep flags
// - table read: two cycles, low byte to memory, high byte to table high register
// - table address from both pointers, or current page, or last page, by option
// - nibble swap in place or to accumulator, one cycle, flags kept
// - watchdog cleared with its flags only once both preclear instructions have run
// - power-down and single watchdog clear take one cycle and update both flags
// - add with carry to accumulator, flags ov z ac c updated
// - add with carry to memory, flags ov z ac c updated
// - add memory to accumulator without carry, flags updated
// - add immediate to accumulator, flags updated
// - add accumulator to memory without carry, flags updated
// - call pushes next address then loads target
// - power-down stops execution, clears watchdog, sets power-down flag, clears timeout
// - single watchdog clear zeroes watchdog and clears both flags
// - jump loads the encoded address into the program counter
`ifndef MBMAE_DEFINES_VH
`define MBMAE_DEFINES_VH
`define MBMAE_OP_NOP 5'h00
`define MBMAE_OP_JMP 5'h01
`define MBMAE_OP_SZ 5'h02
`define MBMAE_OP_SZA 5'h03
`define MBMAE_OP_SZ_BIT 5'h04
`define MBMAE_OP_SNZ_BIT 5'h05
`define MBMAE_OP_SIZ 5'h06
`define MBMAE_OP_SDZ 5'h07
`define MBMAE_OP_INC_SKIP_ZERO_TO_ACC 5'h08
`define MBMAE_OP_DEC_SKIP_ZERO_TO_ACC 5'h09
`define MBMAE_OP_CALL 5'h0a
`define MBMAE_OP_RET 5'h0b
`define MBMAE_OP_RET_IMM 5'h0c
`define MBMAE_OP_INTERRUPT_RETURN 5'h0d
`define MBMAE_OP_TAB_CUR 5'h0e
`define MBMAE_OP_TAB_LAST 5'h0f
`define MBMAE_OP_SWAP 5'h10
`define MBMAE_OP_NIBBLE_SWAP_TO_ACC 5'h11
`define MBMAE_OP_CLR_WDT 5'h12
`define MBMAE_OP_WDT_PRE_A 5'h13
`define MBMAE_OP_WDT_PRE_B 5'h14
`define MBMAE_OP_HALT 5'h15
`define MBMAE_OP_ADC 5'h16
`define MBMAE_OP_ADD_CARRY_TO_MEM 5'h17
`define MBMAE_OP_ADD 5'h18
`define MBMAE_OP_ADDI 5'h19
`define MBMAE_OP_ADD_TO_MEM 5'h1a
`define MBMAE_ST_IDLE 2'h0
`define MBMAE_ST_RUN 2'h1
`define MBMAE_ST_HALT 2'h2
`define MBMAE_CLK_PER_CYC 4'h4
`define MBMAE_CNT_RD 4'h1
`define MBMAE_CNT_EXEC 4'h2
`define MBMAE_CNT_TAB 4'h4
`define MBMAE_PCL_ADDR 8'h06
`define MBMAE_LAST_PAGE 5'h1f
`define MBMAE_PC_RESET 13'h0000
`endif

// ### mbmae_exec.v
// execution unit for jumps, skips, calls, returns, table reads, swap, watchdog clear, halt and adds
// assumes single-cycle memories: read data is valid the clock after the read strobe,
// and all inputs come from logic on clk
`timescale 1ns/10ps
`include "mbmae_defines.vh"
module mbmae_exec (
  input wire clk,
  input wire arst_n,
  input wire instr_valid,
  output wire instr_ready,
  input wire [4:0] instr_op,
  input wire [7:0] instr_addr,
  input wire [2:0] instr_bit,
  input wire [7:0] instr_imm,
  input wire [12:0] instr_target,
  output reg instr_done,
  output reg instr_skip,
  output reg [12:0] pc_reg,
  output reg [7:0] acc_reg,
  output reg carry_flag,
  output reg aux_carry_flag,
  output reg zero_flag,
  output reg overflow_flag,
  output reg watchdog_timeout_flag,
  output reg powerdown_flag,
  output reg [7:0] table_high_byte_reg,
  input wire [7:0] table_pointer_low,
  input wire [7:0] table_pointer_high,
  input wire table_ptr_high_en,
  input wire watchdog_timeout,
  output reg watchdog_clear,
  output wire halted,
  input wire wake_up,
  output reg interrupt_return,
  output reg [7:0] mem_addr,
  output reg mem_rd_en,
  input wire [7:0] mem_rd_data,
  output reg mem_wr_en,
  output reg [7:0] mem_wr_data,
  output reg [12:0] prog_addr,
  output reg prog_rd_en,
  input wire [15:0] prog_rd_data,
  output reg stack_push,
  output reg [12:0] stack_push_data,
  output reg stack_pop,
  input wire [12:0] stack_top
);

  reg [1:0] state_reg, total_reg;
  reg [3:0] cnt_reg;
  reg [4:0] op_reg;
  reg [7:0] addr_reg, imm_reg, pcl_val_reg;
  reg [2:0] bit_reg;
  reg [12:0] target_reg;
  reg skip_reg, pcl_load_reg, pre_a_reg, pre_b_reg;

  // combinational results of the execute step
  reg [7:0] res;
  reg [1:0] base_cycles;
  reg wr_mem, wr_acc, skip, add_flags, uses_mem;

  wire running = (state_reg == `MBMAE_ST_RUN);
  wire accept = instr_valid & instr_ready;
  wire at_exec = running & (cnt_reg == `MBMAE_CNT_EXEC);
  wire at_tab = running & (cnt_reg == `MBMAE_CNT_TAB);
  wire [3:0] end_cnt = {total_reg, 2'b00} - 4'h1;
  wire at_end = running & (cnt_reg == end_cnt) & (cnt_reg > `MBMAE_CNT_EXEC);
  wire dst_pcl = (addr_reg == `MBMAE_PCL_ADDR);
  wire is_table = (op_reg == `MBMAE_OP_TAB_CUR) | (op_reg == `MBMAE_OP_TAB_LAST);

  assign instr_ready = (state_reg == `MBMAE_ST_IDLE);
  assign halted = (state_reg == `MBMAE_ST_HALT);

  // the low program counter byte lives in data space, so reads of it come from the counter
  wire [7:0] rd = dst_pcl ? pc_reg[7:0] : mem_rd_data;
  wire [7:0] inc_val = rd + 8'h01;
  wire [7:0] dec_val = rd - 8'h01;
  wire [7:0] swap_val = {rd[3:0], rd[7:4]};

  // adder with nibble split so aux carry falls out of the low half
  wire add_cin = ((op_reg == `MBMAE_OP_ADC) | (op_reg == `MBMAE_OP_ADD_CARRY_TO_MEM)) & carry_flag;
  wire [7:0] add_b = (op_reg == `MBMAE_OP_ADDI) ? imm_reg : rd;
  wire [4:0] add_lo = {1'b0, acc_reg[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
  wire [4:0] add_hi = {1'b0, acc_reg[7:4]} + {1'b0, add_b[7:4]} + {4'h0, add_lo[4]};
  wire [7:0] add_sum = {add_hi[3:0], add_lo[3:0]};
  wire add_ov = (acc_reg[7] == add_b[7]) & (add_sum[7] != acc_reg[7]);

  // cycle count of each class before penalties
  always @* begin
    base_cycles = 2'h1;
    uses_mem = 1'b0;
    case (instr_op)
      `MBMAE_OP_JMP, `MBMAE_OP_CALL, `MBMAE_OP_RET, `MBMAE_OP_RET_IMM, `MBMAE_OP_INTERRUPT_RETURN, `MBMAE_OP_TAB_CUR,
      `MBMAE_OP_TAB_LAST: begin
        base_cycles = 2'h2;
      end
      `MBMAE_OP_SZ, `MBMAE_OP_SZA, `MBMAE_OP_SZ_BIT, `MBMAE_OP_SNZ_BIT, `MBMAE_OP_SIZ, `MBMAE_OP_SDZ,
      `MBMAE_OP_INC_SKIP_ZERO_TO_ACC, `MBMAE_OP_DEC_SKIP_ZERO_TO_ACC, `MBMAE_OP_SWAP, `MBMAE_OP_NIBBLE_SWAP_TO_ACC, `MBMAE_OP_ADC, `MBMAE_OP_ADD_CARRY_TO_MEM,
      `MBMAE_OP_ADD, `MBMAE_OP_ADD_TO_MEM: begin
        uses_mem = 1'b1;
      end
      default: begin
        base_cycles = 2'h1;
      end
    endcase
  end

  // execute step: result, destination and skip decision
  always @* begin
    res = 8'h00;
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    skip = 1'b0;
    add_flags = 1'b0;
    case (op_reg)
      `MBMAE_OP_SZ: begin
        skip = (rd == 8'h00);
      end
      `MBMAE_OP_SZA: begin
        res = rd;
        wr_acc = 1'b1;
        skip = (rd == 8'h00);
      end
      `MBMAE_OP_SZ_BIT, `MBMAE_OP_SNZ_BIT: begin
        // one form skips on a clear bit, the other on a set bit
        skip = rd[bit_reg] ^ (op_reg == `MBMAE_OP_SZ_BIT);
      end
      `MBMAE_OP_SIZ, `MBMAE_OP_SDZ: begin
        res = (op_reg == `MBMAE_OP_SIZ) ? inc_val : dec_val;
        wr_mem = 1'b1;
        skip = (res == 8'h00);
      end
      `MBMAE_OP_INC_SKIP_ZERO_TO_ACC, `MBMAE_OP_DEC_SKIP_ZERO_TO_ACC: begin
        res = (op_reg == `MBMAE_OP_INC_SKIP_ZERO_TO_ACC) ? inc_val : dec_val;
        wr_acc = 1'b1;
        skip = (res == 8'h00);
      end
      `MBMAE_OP_RET_IMM: begin
        res = imm_reg;
        wr_acc = 1'b1;
      end
      `MBMAE_OP_SWAP, `MBMAE_OP_NIBBLE_SWAP_TO_ACC: begin
        res = swap_val;
        wr_mem = (op_reg == `MBMAE_OP_SWAP);
        wr_acc = (op_reg == `MBMAE_OP_NIBBLE_SWAP_TO_ACC);
      end
      `MBMAE_OP_ADC, `MBMAE_OP_ADD, `MBMAE_OP_ADDI, `MBMAE_OP_ADD_CARRY_TO_MEM, `MBMAE_OP_ADD_TO_MEM: begin
        res = add_sum;
        wr_mem = (op_reg == `MBMAE_OP_ADD_CARRY_TO_MEM) | (op_reg == `MBMAE_OP_ADD_TO_MEM);
        wr_acc = ~wr_mem;
        add_flags = 1'b1;
      end
      default: begin
        res = 8'h00;
      end
    endcase
  end

  // sequencer: four clocks per instruction cycle, penalties decided at the execute step
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= `MBMAE_ST_IDLE;
      cnt_reg <= 4'h0;
      total_reg <= 2'h1;
      op_reg <= `MBMAE_OP_NOP;
      addr_reg <= 8'h00;
      bit_reg <= 3'h0;
      imm_reg <= 8'h00;
      target_reg <= 13'h0000;
    end else begin
      case (state_reg)
        `MBMAE_ST_IDLE: begin
          cnt_reg <= 4'h0;
          if (accept) begin
            state_reg <= `MBMAE_ST_RUN;
            cnt_reg <= `MBMAE_CNT_RD;
            total_reg <= base_cycles;
            op_reg <= instr_op;
            addr_reg <= instr_addr;
            bit_reg <= instr_bit;
            imm_reg <= instr_imm;
            target_reg <= instr_target;
          end
        end
        `MBMAE_ST_RUN: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (at_exec) begin
            // skip and program-counter-low penalties are whole extra cycles
            total_reg <= total_reg + {1'b0, skip} + {1'b0, (wr_mem | is_table) & dst_pcl};
          end
          if (at_end) begin
            cnt_reg <= 4'h0;
            state_reg <= (op_reg == `MBMAE_OP_HALT) ? `MBMAE_ST_HALT : `MBMAE_ST_IDLE;
          end
        end
        `MBMAE_ST_HALT: begin
          // execution stays stopped until an outside wake-up
          state_reg <= wake_up ? `MBMAE_ST_IDLE : `MBMAE_ST_HALT;
        end
        default: begin
          state_reg <= `MBMAE_ST_IDLE;
        end
      endcase
    end
  end

  // accumulator, arithmetic flags and the pending program counter low load
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= 8'h00;
      carry_flag <= 1'b0;
      aux_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      overflow_flag <= 1'b0;
      skip_reg <= 1'b0;
      pcl_load_reg <= 1'b0;
      pcl_val_reg <= 8'h00;
      table_high_byte_reg <= 8'h00;
    end else begin
      if (accept) begin
        skip_reg <= 1'b0;
        pcl_load_reg <= 1'b0;
      end
      if (at_exec) begin
        skip_reg <= skip;
        if (wr_acc) begin
          acc_reg <= res;
        end
        if (wr_mem & dst_pcl) begin
          pcl_load_reg <= 1'b1;
          pcl_val_reg <= res;
        end
        if (add_flags) begin
          carry_flag <= add_hi[4];
          aux_carry_flag <= add_lo[4];
          zero_flag <= (add_sum == 8'h00);
          overflow_flag <= add_ov;
        end
      end
      if (at_tab & is_table) begin
        table_high_byte_reg <= prog_rd_data[15:8];
        if (dst_pcl) begin
          pcl_load_reg <= 1'b1;
          pcl_val_reg <= prog_rd_data[7:0];
        end
      end
    end
  end

  // timeout and power-down flags; a timeout in the clearing cycle still sets its flag
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
      watchdog_clear <= 1'b0;
      pre_a_reg <= 1'b0;
      pre_b_reg <= 1'b0;
    end else begin
      watchdog_clear <= 1'b0;
      if (at_exec) begin
        case (op_reg)
          `MBMAE_OP_CLR_WDT, `MBMAE_OP_HALT: begin
            // power-down raises its flag, a plain clear drops it
            watchdog_clear <= 1'b1;
            powerdown_flag <= (op_reg == `MBMAE_OP_HALT);
            watchdog_timeout_flag <= 1'b0;
          end
          `MBMAE_OP_WDT_PRE_A, `MBMAE_OP_WDT_PRE_B: begin
            // the pair completes only when the other preclear is already pending
            if ((op_reg == `MBMAE_OP_WDT_PRE_A) ? pre_b_reg : pre_a_reg) begin
              watchdog_clear <= 1'b1;
              powerdown_flag <= 1'b0;
              watchdog_timeout_flag <= 1'b0;
              pre_a_reg <= 1'b0;
              pre_b_reg <= 1'b0;
            end else if (op_reg == `MBMAE_OP_WDT_PRE_A) begin
              pre_a_reg <= 1'b1;
            end else begin
              pre_b_reg <= 1'b1;
            end
          end
          default: begin
            pre_a_reg <= pre_a_reg;
          end
        endcase
      end
      if (watchdog_timeout) begin
        watchdog_timeout_flag <= 1'b1;
      end
    end
  end

  // memory, program memory and stack strobes, all registered
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_addr <= 8'h00;
      mem_rd_en <= 1'b0;
      mem_wr_en <= 1'b0;
      mem_wr_data <= 8'h00;
      prog_addr <= 13'h0000;
      prog_rd_en <= 1'b0;
      stack_push <= 1'b0;
      stack_push_data <= 13'h0000;
      stack_pop <= 1'b0;
    end else begin
      mem_rd_en <= accept & uses_mem;
      mem_wr_en <= 1'b0;
      prog_rd_en <= 1'b0;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      if (accept) begin
        mem_addr <= instr_addr;
      end
      if (at_exec) begin
        if (wr_mem & ~dst_pcl) begin
          mem_wr_en <= 1'b1;
          mem_wr_data <= res;
        end
        if (op_reg == `MBMAE_OP_CALL) begin
          stack_push <= 1'b1;
          stack_push_data <= pc_reg + 13'h0001;
        end
        if ((op_reg == `MBMAE_OP_RET) | (op_reg == `MBMAE_OP_RET_IMM) | (op_reg == `MBMAE_OP_INTERRUPT_RETURN)) begin
          stack_pop <= 1'b1;
        end
        if (is_table) begin
          prog_rd_en <= 1'b1;
          // the pointer option picks the page source for the current-page form
          prog_addr <= (op_reg == `MBMAE_OP_TAB_LAST) ? {`MBMAE_LAST_PAGE, table_pointer_low} :
                       table_ptr_high_en ? {table_pointer_high[4:0], table_pointer_low} :
                       {pc_reg[12:8], table_pointer_low};
        end
      end
      if (at_tab & is_table & ~dst_pcl) begin
        mem_wr_en <= 1'b1;
        mem_wr_data <= prog_rd_data[7:0];
      end
    end
  end

  // program counter moves at the last clock; a low-byte load wins over a skip
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg <= `MBMAE_PC_RESET;
      instr_done <= 1'b0;
      instr_skip <= 1'b0;
      interrupt_return <= 1'b0;
    end else begin
      instr_done <= at_end;
      instr_skip <= at_end & skip_reg;
      interrupt_return <= at_end & (op_reg == `MBMAE_OP_INTERRUPT_RETURN);
      if (at_end) begin
        case (op_reg)
          `MBMAE_OP_JMP, `MBMAE_OP_CALL: begin
            pc_reg <= target_reg;
          end
          `MBMAE_OP_RET, `MBMAE_OP_RET_IMM, `MBMAE_OP_INTERRUPT_RETURN: begin
            pc_reg <= stack_top;
          end
          default: begin
            if (pcl_load_reg) begin
              pc_reg <= {pc_reg[12:8], pcl_val_reg};
            end else begin
              pc_reg <= pc_reg + {12'h000, 1'b1} + {12'h000, skip_reg};
            end
          end
        endcase
      end
    end
  end

endmodule // mbmae_exec

// ### mbmae_checker.sv
// concurrent checks on the ports of the execution unit
// assumes the opcode macros of mbmae_defines.vh and one clock domain
`timescale 1ns/10ps
`include "mbmae_defines.vh"
module mbmae_checker (
  input wire clk,
  input wire arst_n,
  input wire instr_valid,
  input wire instr_ready,
  input wire [4:0] instr_op,
  input wire [7:0] instr_addr,
  input wire instr_done,
  input wire instr_skip,
  input wire carry_flag,
  input wire aux_carry_flag,
  input wire zero_flag,
  input wire overflow_flag,
  input wire watchdog_timeout_flag,
  input wire powerdown_flag,
  input wire watchdog_clear,
  input wire halted,
  input wire mem_wr_en,
  input wire stack_push,
  input wire stack_pop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // a take edge, and the flags that skips must leave alone
  wire take = instr_valid && instr_ready;
  wire [3:0] flags = {carry_flag, aux_carry_flag, zero_flag, overflow_flag};
  wire is_ret = instr_op == `MBMAE_OP_RET || instr_op == `MBMAE_OP_RET_IMM || instr_op == `MBMAE_OP_INTERRUPT_RETURN;
  wire is_skip = instr_op >= `MBMAE_OP_SZ && instr_op <= `MBMAE_OP_DEC_SKIP_ZERO_TO_ACC;
  chk_jump_len: assert property (take && instr_op == `MBMAE_OP_JMP |-> ##8 instr_done)
    else $error("jump length wrong");
  chk_call_push: assert property (take && instr_op == `MBMAE_OP_CALL |-> ##3 stack_push ##5 instr_done)
    else $error("call push or length wrong");
  chk_ret_pop: assert property (take && is_ret |-> ##3 stack_pop ##5 instr_done)
    else $error("return pop or length wrong");
  chk_skip_flags: assert property (take && is_skip |-> ##1 ($stable(flags))[*4])
    else $error("skip changed a flag");
  chk_skip_extra: assert property (instr_skip |-> instr_done && !$past(instr_ready, 4))
    else $error("skip without extra cycle");
  chk_pcl_swap: assert property (take && instr_op == `MBMAE_OP_SWAP && instr_addr == 8'h06 |->
    ##1 (!instr_done)[*7] ##1 instr_done)
    else $error("low byte load without extra cycle");
  chk_halt_flags: assert property (take && instr_op == `MBMAE_OP_HALT |->
    ##3 watchdog_clear ##1 powerdown_flag && !watchdog_timeout_flag && halted)
    else $error("halt did not clear watchdog or set flags");
  chk_tab_write: assert property (take && instr_op == `MBMAE_OP_TAB_LAST && instr_addr != 8'h06 |->
    ##5 mem_wr_en ##3 instr_done)
    else $error("table read timing wrong");
  chk_busy_ready: assert property (take |=> (!instr_ready)[*3])
    else $error("ready inside an instruction cycle");
  cov_call: cover property (take && instr_op == `MBMAE_OP_CALL);
  cov_skip: cover property (instr_skip);
  cov_halt: cover property (halted);
endmodule // mbmae_checker

// ### mbmae_mem_model.sv
// data memory, program memory and return stack facing the execution unit
// assumes requests launched on clk; answers land one clock after each read strobe
`timescale 1ns/10ps
module mbmae_mem_model (
  input wire clk,
  input wire [7:0] mem_addr,
  input wire mem_rd_en,
  output reg [7:0] mem_rd_data,
  input wire mem_wr_en,
  input wire [7:0] mem_wr_data,
  input wire [12:0] prog_addr,
  input wire prog_rd_en,
  output reg [15:0] prog_rd_data,
  input wire stack_push,
  input wire [12:0] stack_push_data,
  input wire stack_pop,
  output reg [12:0] stack_top
);
  reg [7:0] mem [0:255];
  reg [12:0] stk [0:7];
  reg [2:0] sp = 3'h0;
  initial begin
    mem_rd_data = 8'h00;
    prog_rd_data = 16'h0000;
    stack_top = 13'h0000;
  end
  // idle buses show the inverse, so stale data never passes for an answer
  always @(posedge clk) begin
    mem_rd_data <= mem_rd_en ? mem[mem_addr] : ~mem_rd_data;
    prog_rd_data <= prog_rd_en ? {prog_addr[7:0] ^ 8'h3c, 3'h5, prog_addr[12:8]} : ~prog_rd_data;
    if (mem_wr_en)
      mem[mem_addr] <= mem_wr_data;
    // the popped entry stays on the top lines until the next pop
    if (stack_push) begin
      stk[sp] <= stack_push_data;
      sp <= sp + 3'h1;
    end else if (stack_pop) begin
      stack_top <= stk[sp - 3'h1];
      sp <= sp - 3'h1;
    end
  end
endmodule // mbmae_mem_model

// ### mcu_branch_misc_add_exec_bench.sv
// self-checking bench: adds, skips, swaps, branches, table reads, watchdog clears and halt
// assumes the memory model answers reads and keeps the return stack
`timescale 1ns/10ps
`include "mbmae_defines.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module mcu_branch_misc_add_exec_bench;
  reg clk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0, table_ptr_high_en = 1'b0, watchdog_timeout = 1'b0;
  reg wake_up = 1'b0;
  reg [4:0] instr_op = 5'h00, o;
  reg [7:0] instr_addr = 8'h00, instr_imm = 8'h00, table_pointer_low = 8'h00, table_pointer_high = 8'h00;
  reg [2:0] instr_bit = 3'h0;
  reg [12:0] instr_target = 13'h0000, epc = 13'h0000, t1, pa;
  reg [12:0] pstk [0:2];
  wire instr_ready, instr_done, instr_skip, halted, watchdog_clear, interrupt_return, mem_rd_en, mem_wr_en;
  wire prog_rd_en, stack_push, stack_pop, carry_flag, aux_carry_flag, zero_flag, overflow_flag;
  wire watchdog_timeout_flag, powerdown_flag;
  wire [12:0] pc_reg, prog_addr, stack_push_data, stack_top;
  wire [7:0] acc_reg, table_high_byte_reg, mem_addr, mem_rd_data, mem_wr_data;
  wire [15:0] prog_rd_data;
  integer error_cnt = 0, tests_run = 0, ncyc, nwclr = 0, i, k;
  reg [7:0] ea = 8'h00, d, x;
  reg ec = 1'b0, eac = 1'b0, eov = 1'b0, ez = 1'b0, es, ei;
  reg [10:0] s;
  reg [8:0] sk;
  reg [15:0] w;
  localparam [34:0] WOPS = {`MBMAE_OP_HALT, `MBMAE_OP_WDT_PRE_A, `MBMAE_OP_WDT_PRE_B, `MBMAE_OP_CLR_WDT,
    `MBMAE_OP_WDT_PRE_B, `MBMAE_OP_WDT_PRE_A, `MBMAE_OP_WDT_PRE_A};
  localparam [6:0] WTO = 7'b0010011;
  localparam [6:0] WCL = 7'b1101100;
  mbmae_exec dut (.clk, .arst_n, .instr_valid, .instr_ready, .instr_op, .instr_addr, .instr_bit, .instr_imm,
    .instr_target, .instr_done, .instr_skip, .pc_reg, .acc_reg, .carry_flag, .aux_carry_flag, .zero_flag,
    .overflow_flag, .watchdog_timeout_flag, .powerdown_flag, .table_high_byte_reg, .table_pointer_low,
    .table_pointer_high, .table_ptr_high_en, .watchdog_timeout, .watchdog_clear, .halted, .wake_up,
    .interrupt_return, .mem_addr, .mem_rd_en, .mem_rd_data, .mem_wr_en, .mem_wr_data, .prog_addr, .prog_rd_en,
    .prog_rd_data, .stack_push, .stack_push_data, .stack_pop, .stack_top);
  mbmae_mem_model u_mem (.clk, .mem_addr, .mem_rd_en, .mem_rd_data, .mem_wr_en, .mem_wr_data, .prog_addr,
    .prog_rd_en, .prog_rd_data, .stack_push, .stack_push_data, .stack_pop, .stack_top);
  // sum with overflow, aux carry and carry above the byte
  function [10:0] addf(input [7:0] a, input [7:0] b, input ci);
    reg [8:0] s9;
    reg [4:0] s5;
    begin
      s9 = a + b + ci;
      s5 = a[3:0] + b[3:0] + ci;
      addf = {(a[7] == b[7]) && (s9[7] != a[7]), s5[4], s9[8], s9[7:0]};
    end
  endfunction
  // skip decision over the tested byte, with the inc or dec result below it
  function [8:0] skf(input [4:0] op, input [7:0] v, input [2:0] b);
    reg [7:0] r;
    begin
      r = (op == `MBMAE_OP_SIZ || op == `MBMAE_OP_INC_SKIP_ZERO_TO_ACC) ? v + 8'h01 :
          (op == `MBMAE_OP_SDZ || op == `MBMAE_OP_DEC_SKIP_ZERO_TO_ACC) ? v - 8'h01 : v;
      skf = {(op == `MBMAE_OP_SZ_BIT) ? !v[b] : (op == `MBMAE_OP_SNZ_BIT) ? v[b] : (r == 8'h00), r};
    end
  endfunction
  initial begin
    forever #50 clk = ~clk;
  end
  // watchdog clear pulses seen on the port
  always @(posedge clk)
    if (watchdog_clear === 1'b1)
      nwclr++;
  task summarize;
    begin
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // offer one instruction, hold it until taken, count clocks up to the done pulse
  task ex(input [4:0] op, input [7:0] a, input [7:0] v, input [12:0] t);
    begin
      instr_op = op;
      instr_addr = a;
      instr_imm = v;
      instr_bit = v[2:0];
      instr_target = t;
      instr_valid = 1'b1;
      ncyc = 0;
      while (instr_ready !== 1'b1 && ncyc < 50) begin
        @(posedge clk);
        #1 ncyc++;
      end
      @(posedge clk);
      #1 instr_valid = 1'b0;
      ncyc = 1;
      while (instr_done !== 1'b1 && ncyc < 20) begin
        @(posedge clk);
        #1 ncyc++;
      end
      es = instr_skip;
      ei = interrupt_return;
    end
  endtask
  task fin(input integer n, input sk_i, input [12:0] npc);
    begin
      `CHK(ncyc, n)
      `CHK(es, sk_i)
      epc = npc;
      `CHK(pc_reg, epc)
    end
  endtask
  task flg;
    begin
      `CHK(acc_reg, ea)
      `CHK({overflow_flag, aux_carry_flag, carry_flag, zero_flag}, {eov, eac, ec, ez})
    end
  endtask
  initial begin
    #(3000 * 100);
    error_cnt++;
    summarize;
  end
  initial begin
    void'($urandom(85141));
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    flg;
    // adds: sign-boundary operands first, then random, the five forms in turn
    for (i = 0; i < 30; i++) begin
      o = `MBMAE_OP_ADC + 5'(i % 5);
      k = 8'h20 + i;
      d = (i < 10) ? 8'h7f + 8'(i % 2) : 8'($urandom);
      x = 8'($urandom);
      u_mem.mem[k] = d;
      s = addf(ea, (o == `MBMAE_OP_ADDI) ? x : d, (o <= `MBMAE_OP_ADD_CARRY_TO_MEM) ? ec : 1'b0);
      ex(o, 8'(k), x, 13'h0000);
      fin(4, 1'b0, epc + 13'h1);
      if (o == `MBMAE_OP_ADD_CARRY_TO_MEM || o == `MBMAE_OP_ADD_TO_MEM)
        `CHK(u_mem.mem[k], s[7:0])
      else
        ea = s[7:0];
      {eov, eac, ec} = s[10:8];
      ez = (s[7:0] == 8'h00);
      flg;
    end
    // skips: a byte that skips, its complement that does not, then random bytes
    for (i = 0; i < 24; i++) begin
      o = `MBMAE_OP_SZ + 5'(i % 8);
      k = 8'h40 + i;
      x = 8'($urandom);
      d = (o == `MBMAE_OP_SNZ_BIT || o == `MBMAE_OP_SIZ || o == `MBMAE_OP_INC_SKIP_ZERO_TO_ACC) ? 8'hff :
          (o == `MBMAE_OP_SDZ || o == `MBMAE_OP_DEC_SKIP_ZERO_TO_ACC) ? 8'h01 : 8'h00;
      d = (i < 8) ? d : (i < 16) ? ~d : 8'($urandom);
      u_mem.mem[k] = d;
      sk = skf(o, d, x[2:0]);
      ex(o, 8'(k), x, 13'h0000);
      fin(sk[8] ? 8 : 4, sk[8], epc + (sk[8] ? 13'h2 : 13'h1));
      if (o == `MBMAE_OP_SZA || o == `MBMAE_OP_INC_SKIP_ZERO_TO_ACC || o == `MBMAE_OP_DEC_SKIP_ZERO_TO_ACC)
        ea = sk[7:0];
      `CHK(u_mem.mem[k], (o == `MBMAE_OP_SIZ || o == `MBMAE_OP_SDZ) ? sk[7:0] : d)
      flg;
    end
    // swap to the accumulator, in place, then onto the program counter low byte
    d = 8'($urandom);
    u_mem.mem[8'h30] = d;
    ex(`MBMAE_OP_NIBBLE_SWAP_TO_ACC, 8'h30, 8'h00, 13'h0000);
    ea = {d[3:0], d[7:4]};
    fin(4, 1'b0, epc + 13'h1);
    flg;
    ex(`MBMAE_OP_SWAP, 8'h30, 8'h00, 13'h0000);
    fin(4, 1'b0, epc + 13'h1);
    `CHK(u_mem.mem[8'h30], ea)
    ex(`MBMAE_OP_SWAP, 8'h06, 8'h00, 13'h0000);
    fin(8, 1'b0, {epc[12:8], epc[3:0], epc[7:4]});
    t1 = 13'($urandom);
    ex(`MBMAE_OP_JMP, 8'h00, 8'h00, t1);
    fin(8, 1'b0, t1);
    // three nested calls unwound by the three return forms
    for (i = 0; i < 3; i++) begin
      pstk[i] = epc + 13'h1;
      t1 = 13'($urandom);
      ex(`MBMAE_OP_CALL, 8'h00, 8'h00, t1);
      fin(8, 1'b0, t1);
    end
    for (i = 2; i >= 0; i--) begin
      x = 8'($urandom);
      ex(`MBMAE_OP_RET + 5'(2 - i), 8'h00, x, 13'h0000);
      if (i == 1)
        ea = x;
      fin(8, 1'b0, pstk[i]);
      `CHK(ei, i == 0)
      flg;
    end
    // table reads: both pointers, current page, last page, last page onto the low byte
    for (i = 0; i < 4; i++) begin
      table_pointer_low = 8'($urandom);
      table_pointer_high = 8'($urandom);
      table_ptr_high_en = (i == 0);
      pa = (i == 0) ? {table_pointer_high[4:0], table_pointer_low} :
           (i == 1) ? {epc[12:8], table_pointer_low} : {5'h1f, table_pointer_low};
      w = {pa[7:0] ^ 8'h3c, 3'h5, pa[12:8]};
      ex((i < 2) ? `MBMAE_OP_TAB_CUR : `MBMAE_OP_TAB_LAST, (i == 3) ? 8'h06 : 8'h50, 8'h00, 13'h0000);
      fin((i == 3) ? 12 : 8, 1'b0, (i == 3) ? {epc[12:8], w[7:0]} : epc + 13'h1);
      `CHK(table_high_byte_reg, w[15:8])
      if (i < 3)
        `CHK(u_mem.mem[8'h50], w[7:0])
    end
    // timeout raised before each clear step; single and repeated preclears must not clear
    for (i = 0; i < 7; i++) begin
      watchdog_timeout = 1'b1;
      @(posedge clk);
      #1 watchdog_timeout = 1'b0;
      k = nwclr;
      ex(WOPS[i * 5 +: 5], 8'h00, 8'h00, 13'h0000);
      fin(4, 1'b0, epc + 13'h1);
      `CHK(watchdog_timeout_flag, WTO[i])
      `CHK(powerdown_flag, i == 6)
      `CHK(nwclr - k, WCL[i])
    end
    `CHK(halted, 1'b1)
    `CHK(instr_ready, 1'b0)
    wake_up = 1'b1;
    @(posedge clk);
    #1 wake_up = 1'b0;
    `CHK(halted, 1'b0)
    summarize;
  end
endmodule // mcu_branch_misc_add_exec_bench
bind mbmae_exec mbmae_checker u_chk (.clk, .arst_n, .instr_valid, .instr_ready, .instr_op, .instr_addr,
  .instr_done, .instr_skip, .carry_flag, .aux_carry_flag, .zero_flag, .overflow_flag, .watchdog_timeout_flag,
  .powerdown_flag, .watchdog_clear, .halted, .mem_wr_en, .stack_push, .stack_pop);
